// [hdl/wdtmr_pkg.sv]
// Constants and carrier types for the watchdog timer.
// Assumes a single system clock at 20 MHz and a synchronous active-high reset.
package wdtmr_pkg;

    // =====================================================================
    // Widths and prescaler ratios
    localparam int unsigned        WDTMR_CNT_W      = 16;
    localparam int unsigned        WDTMR_PRE_W      = 14;
    localparam logic [13:0]        WDTMR_PRE_SLOW   = 14'h3fff; // 16,384 - 1
    localparam logic [13:0]        WDTMR_PRE_FAST   = 14'h00ff; // 256 - 1
    localparam logic               WDTMR_SEL_SLOW   = 1'b1;
    localparam logic               WDTMR_SEL_FAST   = 1'b0;

    // =====================================================================
    // Power-up settings: 254 ticks of 256 clocks, 3.25 ms at the 20 MHz clock
    localparam logic [15:0]        WDTMR_RELOAD_RST = 16'hff02;
    localparam logic               WDTMR_SEL_RST    = WDTMR_SEL_FAST;
    localparam logic [15:0]        WDTMR_CNT_MAX    = 16'hffff;

    // =====================================================================
    // Timing
    localparam int unsigned        WDTMR_CLK_HZ     = 20_000_000;
    localparam int unsigned        WDTMR_GAP_NS     = 800;
    localparam int unsigned        WDTMR_GAP_CYC_I  = (WDTMR_GAP_NS * (WDTMR_CLK_HZ / 1_000_000)
                                                       + 999) / 1000;
    localparam logic [7:0]         WDTMR_GAP_CYC    = WDTMR_GAP_CYC_I[7:0];

    // =====================================================================
    // Types
    typedef enum logic [3:0]
    {
        WDTMR_ST_RUN  = 4'b0001,
        WDTMR_ST_STOP = 4'b0010,
        WDTMR_ST_WARN = 4'b0100,
        WDTMR_ST_FAIL = 4'b1000
    } wdtmr_state_type;

    typedef struct packed
    {
        logic        service;
        logic        disable_instr;
        logic        enable_instr;
        logic        cfg_wr;
        logic [15:0] cfg_reload;
        logic        cfg_sel;
    } wdtmr_ctrl_type;

    typedef struct packed
    {
        logic        prewarn_irq;
        logic        reset_req;
        logic        running;
        logic [15:0] count;
    } wdtmr_stat_type;

endpackage

// [hdl/wdtmr_prescaler.sv]
// Prescaler that divides the system clock by 16,384 or 256.
// Assumes clear and run come from logic on the same clock.
`timescale 1ns/1ns
module wdtmr_prescaler
    import wdtmr_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic run,
    input  wire logic clear,
    input  wire logic sel,
    output logic      tick
);

    // =====================================================================
    // State
    typedef struct packed
    {
        logic [13:0] cnt;
        logic        tick;
    } wdtmr_pre_type;

    wdtmr_pre_type pre_r;
    wdtmr_pre_type pre_nxt;

    function automatic logic [13:0] wdtmr_limit(input logic s);
        wdtmr_limit = (s == WDTMR_SEL_SLOW) ? WDTMR_PRE_SLOW : WDTMR_PRE_FAST;
    endfunction

    always_comb
    begin
        pre_nxt      = pre_r;
        pre_nxt.tick = 1'b0;
        if (clear)
        begin
            pre_nxt.cnt = '0;
        end
        else if (run)
        begin
            // Compare with >= so a ratio change mid-count cannot run past the limit
            if (pre_r.cnt >= wdtmr_limit(sel))
            begin
                pre_nxt.cnt  = '0;
                pre_nxt.tick = 1'b1;
            end
            else
            begin
                pre_nxt.cnt = pre_r.cnt + 14'h0001;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            pre_r <= '0;
        end
        else
        begin
            pre_r <= pre_nxt;
        end
    end

    assign tick = pre_r.tick;

endmodule

// [hdl/wdtmr_timer.sv]
// Watchdog timer top: 16-bit up counter, service reload, prewarning and reset request.
// Assumes control strobes are one-cycle pulses from the CPU core on clk_sys.
`timescale 1ns/1ns
module wdtmr_timer
    import wdtmr_pkg::*;
(
    input  wire logic           clk_sys,
    input  wire logic           reset,
    input  wire wdtmr_ctrl_type ctrl,
    output wdtmr_stat_type      stat
);

    // =====================================================================
    // State
    typedef struct packed
    {
        wdtmr_state_type state;
        logic [15:0]     count;
        logic [15:0]     reload;
        logic            sel;
        logic [7:0]      gap;
        logic            prewarn_irq;
        logic            reset_req;
        logic            running;
    } wdtmr_core_type;

    localparam wdtmr_core_type WDTMR_CORE_RST = '{
        state:       WDTMR_ST_RUN,
        count:       WDTMR_RELOAD_RST,
        reload:      WDTMR_RELOAD_RST,
        sel:         WDTMR_SEL_RST,
        gap:         8'h00,
        prewarn_irq: 1'b0,
        reset_req:   1'b0,
        running:     1'b1
    };

    wdtmr_core_type core_r;
    wdtmr_core_type core_nxt;
    logic           tick;
    logic           pre_clear;
    logic           pre_run;

    // =====================================================================
    // Prescaler
    assign pre_run   = (core_r.state == WDTMR_ST_RUN);
    assign pre_clear = ctrl.service && (core_r.state != WDTMR_ST_WARN)
                       && (core_r.state != WDTMR_ST_FAIL);

    wdtmr_prescaler u_pre
    (
        .clk_sys (clk_sys),
        .reset   (reset),
        .run     (pre_run),
        .clear   (pre_clear),
        .sel     (core_r.sel),
        .tick    (tick)
    );

    // =====================================================================
    // Control
    always_comb
    begin
        core_nxt             = core_r;
        core_nxt.prewarn_irq = 1'b0;

        // Reload value is for the next load, the ratio select applies at once; neither disturbs the running count
        if (ctrl.cfg_wr)
        begin
            core_nxt.reload = ctrl.cfg_reload;
            core_nxt.sel    = ctrl.cfg_sel;
        end

        case (core_r.state)
            WDTMR_ST_RUN:
            begin
                if (ctrl.disable_instr)
                begin
                    core_nxt.state = WDTMR_ST_STOP;
                end
                if (pre_clear)
                begin
                    core_nxt.count = core_r.reload;
                end
                else if (tick)
                begin
                    if (core_r.count == WDTMR_CNT_MAX)
                    begin
                        // Overflow beats a disable in the same cycle: fail-safe first
                        core_nxt.state       = WDTMR_ST_WARN;
                        core_nxt.prewarn_irq = 1'b1;
                        core_nxt.gap         = WDTMR_GAP_CYC;
                        core_nxt.count       = core_r.reload;
                    end
                    else
                    begin
                        core_nxt.count = core_r.count + 16'h0001;
                    end
                end
            end
            WDTMR_ST_STOP:
            begin
                if (pre_clear)
                begin
                    core_nxt.count = core_r.reload;
                end
                // Disable wins over a simultaneous enable
                if (ctrl.enable_instr && !ctrl.disable_instr)
                begin
                    core_nxt.state = WDTMR_ST_RUN;
                end
            end
            WDTMR_ST_WARN:
            begin
                // Once overflowed, neither service nor disable can cancel the reset
                if (core_r.gap <= 8'h01)
                begin
                    core_nxt.state     = WDTMR_ST_FAIL;
                    core_nxt.reset_req = 1'b1;
                end
                else
                begin
                    core_nxt.gap = core_r.gap - 8'h01;
                end
            end
            WDTMR_ST_FAIL:
            begin
                core_nxt.reset_req = 1'b1;
            end
            default:
            begin
                core_nxt.state = WDTMR_ST_RUN;
            end
        endcase

        core_nxt.running = (core_nxt.state == WDTMR_ST_RUN);
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            core_r <= WDTMR_CORE_RST;
        end
        else
        begin
            core_r <= core_nxt;
        end
    end

    assign stat.prewarn_irq = core_r.prewarn_irq;
    assign stat.reset_req   = core_r.reset_req;
    assign stat.running     = core_r.running;
    assign stat.count       = core_r.count;

endmodule

// [tb/testbench.sv]
// Self-checking bench for the watchdog timer.
// Assumes the CPU model drives every control strobe.
`timescale 1ns/1ns
`define CHK_EQ(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
    $display("unexpected at %0t: value mismatch", $time); end end
module testbench
    import wdtmr_pkg::*;
;
    logic           clk_sys = 1'b0;
    logic           reset = 1'b1;
    logic [15:0]    rel;
    logic [15:0]    held;
    wdtmr_ctrl_type ctrl;
    wdtmr_stat_type stat;
    int             num_errors = 0;
    int             compares = 0;
    // ========
    // Clock, design and CPU model
    always #25 clk_sys = ~clk_sys;
    wdtmr_timer wdtmr_timer_i (.clk_sys(clk_sys), .reset(reset), .ctrl(ctrl), .stat(stat));
    wdtmr_cpu_model wdtmr_cpu_model_i (.clk_sys(clk_sys), .ctrl(ctrl));
    function automatic int unsigned interval(input logic [15:0] r, input logic sel);
        return (32'h10000 - r) * (sel ? 16384 : 256);
    endfunction
    task automatic do_reset;
        @(negedge clk_sys);
        reset = 1'b1;
        repeat (6) @(negedge clk_sys);
        reset = 1'b0;
    endtask
    // Counts clocks to the prewarning; a few cycles of pipeline are allowed
    task automatic expect_overflow(input int unsigned exp);
        int unsigned n;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        while (stat.prewarn_irq !== 1'b1 && n < exp + 50);
        `CHK_EQ(n >= exp && n <= exp + 6, 1'b1)
        `CHK_EQ(stat.running, 1'b0)
        `CHK_EQ(stat.reset_req, 1'b0)
        repeat (20) @(posedge clk_sys);
        #1;
        `CHK_EQ(stat.reset_req, 1'b1)
        do_reset();
    endtask
    task automatic test_done;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        // Default interval alone is about 65k clocks; the whole run stays under 92k
        #(100_000 * 50);
        num_errors++;
        test_done();
    end
    initial
    begin
        void'($urandom(32'hc4a1));
        do_reset();
        `CHK_EQ(stat.count, WDTMR_RELOAD_RST)
        `CHK_EQ(stat.running, 1'b1)
        expect_overflow(interval(WDTMR_RELOAD_RST, WDTMR_SEL_RST));
        wdtmr_cpu_model_i.strobe(3, 16'hffff, WDTMR_SEL_SLOW);
        wdtmr_cpu_model_i.strobe(0);
        expect_overflow(interval(16'hffff, WDTMR_SEL_SLOW));
        repeat (2)
        begin
            rel = 16'hfff0 | 16'($urandom % 16);
            wdtmr_cpu_model_i.strobe(3, rel, WDTMR_SEL_FAST);
            repeat (3)
            begin
                repeat ($urandom % 200) @(negedge clk_sys);
                wdtmr_cpu_model_i.strobe(0);
            end
            expect_overflow(interval(rel, WDTMR_SEL_FAST));
        end
        wdtmr_cpu_model_i.strobe(1);
        held = stat.count;
        repeat (600) @(negedge clk_sys);
        `CHK_EQ(stat.count, held)
        wdtmr_cpu_model_i.strobe(2);
        `CHK_EQ(stat.running, 1'b1)
        repeat (300) @(negedge clk_sys);
        `CHK_EQ(stat.count != held, 1'b1)
        test_done();
    end
endmodule

// [tb/wdtmr_chk.sv]
// Port assertions for the watchdog timer.
// Assumes it is bound to wdtmr_timer with a synchronous reset.
`timescale 1ns/1ns
module wdtmr_chk
    import wdtmr_pkg::*;
(
    input wire logic           clk_sys,
    input wire logic           reset,
    input wire wdtmr_ctrl_type ctrl,
    input wire wdtmr_stat_type stat
);
    // ========
    // Shadow reload value and warn phase; service, enable and disable are ignored once warned
    logic [15:0] reload_r;
    logic        warned_r;
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            reload_r <= WDTMR_RELOAD_RST;
            warned_r <= 1'b0;
        end
        else
        begin
            if (ctrl.cfg_wr)
                reload_r <= ctrl.cfg_reload;
            if (stat.prewarn_irq)
                warned_r <= 1'b1;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    chk_reset_state: assert property (disable iff (1'b0) reset |=> stat.running
        && stat.count == WDTMR_RELOAD_RST && !stat.prewarn_irq && !stat.reset_req)
        else $error("bad state after reset");
    chk_disable_stops: assert property (stat.running && ctrl.disable_instr
        && stat.count != 16'hffff |=> !stat.running) else $error("disable ignored");
    chk_enable_runs: assert property (!stat.running && !warned_r && !stat.prewarn_irq
        && ctrl.enable_instr && !ctrl.disable_instr |=> stat.running)
        else $error("enable ignored");
    chk_service_reload: assert property (ctrl.service && !warned_r && !stat.prewarn_irq
        && stat.count != 16'hffff |=> stat.count == reload_r) else $error("no reload");
    chk_warn_then_reset: assert property (stat.prewarn_irq |-> !stat.reset_req
        ##15 !stat.reset_req ##1 stat.reset_req) else $error("reset request order");
    chk_warn_pulse: assert property (stat.prewarn_irq |=> !stat.prewarn_irq)
        else $error("prewarning too long");
    chk_reset_holds: assert property (stat.reset_req |=> stat.reset_req)
        else $error("reset request dropped");
    chk_count_step: assert property (stat.running && !ctrl.service |=> stat.prewarn_irq
        || stat.count == $past(stat.count) || stat.count == 16'($past(stat.count) + 1))
        else $error("count step wrong");
    chk_overflow_cause: assert property (stat.prewarn_irq |-> $past(stat.count) == 16'hffff
        && stat.count == reload_r) else $error("overflow not from all ones");
endmodule
bind wdtmr_timer wdtmr_chk wdtmr_chk_i (.clk_sys(clk_sys), .reset(reset), .ctrl(ctrl),
    .stat(stat));

// [tb/wdtmr_cpu_model.sv]
// CPU core model issuing watchdog control strobes.
// Assumes strobes launch at the falling edge of clk_sys.
`timescale 1ns/1ns
module wdtmr_cpu_model
    import wdtmr_pkg::*;
(
    input  wire logic     clk_sys,
    output wdtmr_ctrl_type ctrl
);
    // ========
    // One-cycle strobes; idle reload lines show inverted data, not stale data
    initial ctrl = '0;
    task automatic strobe(input int k, input logic [15:0] rel = 16'h0, input logic sel = 1'b0);
        @(negedge clk_sys);
        ctrl.cfg_reload = rel;
        ctrl.cfg_sel = sel;
        ctrl.service = (k == 0);
        ctrl.disable_instr = (k == 1);
        ctrl.enable_instr = (k == 2);
        ctrl.cfg_wr = (k == 3);
        @(negedge clk_sys);
        {ctrl.service, ctrl.disable_instr, ctrl.enable_instr, ctrl.cfg_wr} = 4'h0;
        ctrl.cfg_reload = ~rel;
        ctrl.cfg_sel = ~sel;
    endtask
endmodule
